// >>> jmgc_top.sv
// Measurement gating control of a time-interval jitter engine: gate, arming, inhibit,
// clock source select, lock loss and phase-adjust indication.
// Assumes all pins are synchronous to the 40 MHz clk_sys and a single-cycle register port.
//
// Behaviour
// [R1] Manual gate 1.0 to 1000.0 ms, 0.1 ms steps.
// [R2] Manual gate above 100.0 ms uses 100 ms sub-gates.
// [R3] Sub-gates sum to gate; result updates at end.
// [R4] No slope selected means internal auto arming.
// [R5] First measurement only after arming event.
// [R6] External arming on selected rising or falling edge.
// [R7] Arming delay 0.0 to 1000.0 ms after edge.
// [R8] Source holds arming and inhibit pulses 30 ns.
// [R9] Arming edge may coincide with data edge.
// [R10] Inhibit suspends measurement at selected active level.
// [R11] Inhibit acts anytime, even inside open gate.
// [R12] No polarity selected means inhibit ignored.
// [R13] Regenerated clock only in data-to-clock function; toggles.
// [R14] Regenerated clock always uses its rising edge.
// [R15] Regenerated clock near 27 MHz from disc data.
// [R16] Lock loss: blink, overrange, message, 5 V output.
// [R17] Phase adjustment only in data-to-clock function.
// [R18] Phase mode: blink, both scales, meter shows phase.
// [R19] Fixed 0.1 s, 0.5 s and event gates.
// [R20] External clock: measure to first selected edge.
// [R21] Final shorter sub-gate completes the programmed total.
`timescale 1ns/1ps
module jmgc_top #(
	parameter int unsigned TICK_CYC = jmgc_pkg::TICK_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic external_arming_input,
	input wire logic measure_block_in,
	input wire logic sample_stb,
	input wire logic pll_lock,
	output logic meas_enable,
	output logic subgate_done,
	output logic result_update,
	output logic clk_use_pll,
	output logic clk_edge_rise,
	output logic pll_led,
	output logic lock_lost_message,
	output logic meter_overrange,
	output logic dc_force_5v,
	output logic phase_led,
	output logic scale10_led,
	output logic scale20_led,
	output logic meter_phase_mode,
	output logic [9:0] meter_phase
);
	jmgc_arm_if aif();
	jmgc_pkg::jmgc_state_e st_q;
	logic [10:0] ctrl_q;
	logic [13:0] gate_q;
	logic [13:0] delay_q;
	logic [9:0] phase_q;
	logic pll_sel_q;
	logic [13:0] sub_q;
	logic [13:0] rem_q;
	logic [16:0] evt_q;
	logic [3:0] sub_idx_q;
	logic [13:0] blink_cnt_q;
	logic blink_q;
	logic restart_q;
	logic inh_act;
	logic d2c;
	logic lost;
	logic [13:0] tot_u;
	logic [13:0] first_u;

	// Saturate a 0.1 ms setting to its legal range.
	function automatic logic [13:0] clamp_u(input logic [31:0] v, input logic [13:0] lo,
		input logic [13:0] hi);
		if (v < {18'h0, lo}) begin
			return lo;
		end else if (v > {18'h0, hi}) begin
			return hi;
		end
		return v[13:0];
	endfunction : clamp_u

	// Length of the next sub-gate: 100 ms chunks, the tail takes what is left.
	function automatic logic [13:0] chunk_u(input logic [13:0] left);
		return (left > jmgc_pkg::SUB_U) ? jmgc_pkg::SUB_U : left; // [R21]
	endfunction : chunk_u

	jmgc_tick #(.CYC(TICK_CYC)) u_tick (
		.clk_sys(clk_sys),
		.rst(rst),
		.tif(aif)
	);

	jmgc_arm u_arm (
		.clk_sys(clk_sys),
		.rst(rst),
		.aif(aif)
	);

	// ==========================================================
	// Interface drive toward the arming detector and divider.
	assign aif.restart = restart_q;
	assign aif.slope = ctrl_q[jmgc_pkg::C_SLOPE +: 2];
	assign aif.delay_u = delay_q;
	assign aif.arm_in = external_arming_input;
	assign aif.tick_clr = aif.fire;

	// Decoded configuration.
	assign d2c = ctrl_q[jmgc_pkg::C_D2C];
	assign lost = pll_sel_q && !pll_lock;
	assign inh_act = (ctrl_q[jmgc_pkg::C_INH +: 2] == jmgc_pkg::INH_POS) ? measure_block_in : // [R10]
		(ctrl_q[jmgc_pkg::C_INH +: 2] == jmgc_pkg::INH_NEG) ? !measure_block_in : 1'b0; // [R12]

	// Total gate for the selected gate kind, in 0.1 ms units.
	always_comb begin
		case (ctrl_q[jmgc_pkg::C_GATE +: 2])
			jmgc_pkg::G_FIX1: tot_u = jmgc_pkg::FIX1_U; // [R19]
			jmgc_pkg::G_FIX5: tot_u = jmgc_pkg::FIX5_U; // [R19]
			jmgc_pkg::G_MAN: tot_u = gate_q; // [R1]
			default: tot_u = 14'd0;
		endcase
		first_u = (ctrl_q[jmgc_pkg::C_GATE +: 2] == jmgc_pkg::G_MAN) ? chunk_u(tot_u) : tot_u; // [R2]
	end

	// ==========================================================
	// Register writes; phase settings and clock toggle need the data-to-clock function.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_q <= jmgc_pkg::CTRL_RST;
			gate_q <= jmgc_pkg::GATE_RST;
			delay_q <= jmgc_pkg::DELAY_RST;
			phase_q <= jmgc_pkg::PHASE_RST;
			pll_sel_q <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == jmgc_pkg::A_CTRL) begin
				ctrl_q <= reg_wdata[10:0];
				if (!reg_wdata[jmgc_pkg::C_D2C]) begin
					ctrl_q[jmgc_pkg::C_PHASE] <= 1'b0; // [R17]
				end
			end
			if (reg_wr && reg_addr == jmgc_pkg::A_GATE) begin
				gate_q <= clamp_u(reg_wdata, jmgc_pkg::GATE_MIN_U, jmgc_pkg::GATE_MAX_U); // [R1]
			end
			if (reg_wr && reg_addr == jmgc_pkg::A_DELAY) begin
				delay_q <= clamp_u(reg_wdata, 14'd0, jmgc_pkg::DLY_MAX_U); // [R7]
			end
			if (reg_wr && reg_addr == jmgc_pkg::A_PHASE && d2c) begin
				phase_q <= (reg_wdata[9:0] > jmgc_pkg::PHASE_MAX) ? jmgc_pkg::PHASE_MAX :
					reg_wdata[9:0]; // [R18]
			end
			if (!d2c) begin
				pll_sel_q <= 1'b0; // [R13]
			end else if (reg_wr && reg_addr == jmgc_pkg::A_CMD && reg_wdata[jmgc_pkg::K_PLL]) begin
				pll_sel_q <= !pll_sel_q; // [R13]
			end
		end
	end

	// ==========================================================
	// Gate sequencer: wait for arming, run sub-gates, publish one result.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_q <= jmgc_pkg::S_IDLE;
			sub_q <= '0;
			rem_q <= '0;
			evt_q <= '0;
			sub_idx_q <= '0;
			restart_q <= 1'b0;
			subgate_done <= 1'b0;
			result_update <= 1'b0;
		end else begin
			restart_q <= 1'b0;
			subgate_done <= 1'b0;
			result_update <= 1'b0;
			case (st_q)
				jmgc_pkg::S_IDLE: begin
					if (ctrl_q[jmgc_pkg::C_RUN]) begin
						restart_q <= 1'b1;
						st_q <= jmgc_pkg::S_ARM;
					end
				end
				jmgc_pkg::S_ARM: begin
					if (!ctrl_q[jmgc_pkg::C_RUN]) begin
						st_q <= jmgc_pkg::S_IDLE;
					end else if (aif.fire) begin
						sub_q <= first_u; // [R5]
						rem_q <= tot_u - first_u;
						evt_q <= '0;
						sub_idx_q <= '0;
						st_q <= jmgc_pkg::S_GATE;
					end
				end
				jmgc_pkg::S_GATE: begin
					if (meas_enable && sample_stb) begin
						evt_q <= evt_q + 17'd1;
					end
					if (ctrl_q[jmgc_pkg::C_GATE +: 2] == jmgc_pkg::G_EVENT) begin
						if (meas_enable && sample_stb && evt_q == jmgc_pkg::EVENT_N - 17'd1) begin
							st_q <= jmgc_pkg::S_DONE; // [R19]
						end
					end else if (aif.tick) begin
						if (sub_q > 14'd1) begin
							sub_q <= sub_q - 14'd1;
						end else if (rem_q == 14'd0) begin
							st_q <= jmgc_pkg::S_DONE; // [R3]
						end else begin
							sub_q <= chunk_u(rem_q); // [R21]
							rem_q <= rem_q - chunk_u(rem_q);
							subgate_done <= 1'b1; // [R2]
							sub_idx_q <= sub_idx_q + 4'd1;
							st_q <= jmgc_pkg::S_SUB;
						end
					end
				end
				jmgc_pkg::S_SUB: begin
					st_q <= jmgc_pkg::S_GATE; // [R2]
				end
				jmgc_pkg::S_DONE: begin
					result_update <= 1'b1; // [R3]
					st_q <= jmgc_pkg::S_IDLE;
				end
				default: begin
					st_q <= jmgc_pkg::S_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Measurement enable: open gate minus inhibit and lock loss, checked every cycle.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meas_enable <= 1'b0;
		end else begin
			meas_enable <= (st_q == jmgc_pkg::S_GATE) && !inh_act && !lost; // [R11]
		end
	end

	// ==========================================================
	// Clock source and reference edge toward the interval counter.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			clk_use_pll <= 1'b0;
			clk_edge_rise <= 1'b1;
		end else begin
			clk_use_pll <= pll_sel_q; // [R15]
			clk_edge_rise <= pll_sel_q ? 1'b1 : !ctrl_q[jmgc_pkg::C_CFALL]; // [R14] [R20]
		end
	end

	// ==========================================================
	// Indicator blink timebase from the 0.1 ms tick.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			blink_cnt_q <= '0;
			blink_q <= 1'b0;
		end else if (aif.tick) begin
			if (blink_cnt_q == jmgc_pkg::BLINK_U - 14'd1) begin
				blink_cnt_q <= '0;
				blink_q <= !blink_q;
			end else begin
				blink_cnt_q <= blink_cnt_q + 14'd1;
			end
		end
	end

	// ==========================================================
	// Front panel, meter and analog output drive.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pll_led <= 1'b0;
			lock_lost_message <= 1'b0;
			meter_overrange <= 1'b0;
			dc_force_5v <= 1'b0;
			phase_led <= 1'b0;
			scale10_led <= 1'b1;
			scale20_led <= 1'b0;
			meter_phase_mode <= 1'b0;
			meter_phase <= '0;
		end else begin
			pll_led <= pll_sel_q && (pll_lock || blink_q); // [R16]
			lock_lost_message <= lost; // [R16]
			meter_overrange <= lost; // [R16]
			dc_force_5v <= lost; // [R16]
			phase_led <= ctrl_q[jmgc_pkg::C_PHASE] && blink_q; // [R18]
			scale10_led <= ctrl_q[jmgc_pkg::C_PHASE] || !ctrl_q[jmgc_pkg::C_SCALE]; // [R18]
			scale20_led <= ctrl_q[jmgc_pkg::C_PHASE] || ctrl_q[jmgc_pkg::C_SCALE]; // [R18]
			meter_phase_mode <= ctrl_q[jmgc_pkg::C_PHASE]; // [R17]
			meter_phase <= phase_q; // [R18]
		end
	end

	// ==========================================================
	// Read port: data one cycle after the strobe, zero for unmapped offsets.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				jmgc_pkg::A_CTRL: reg_rdata <= {21'h0, ctrl_q};
				jmgc_pkg::A_GATE: reg_rdata <= {18'h0, gate_q};
				jmgc_pkg::A_DELAY: reg_rdata <= {18'h0, delay_q};
				jmgc_pkg::A_PHASE: reg_rdata <= {22'h0, phase_q};
				jmgc_pkg::A_STATUS: reg_rdata <= {8'h0, 3'(st_q), lost, pll_sel_q, inh_act,
					sub_idx_q, evt_q[13:0]};
				default: reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end
endmodule : jmgc_top

// >>> jmgc_pkg.sv
// Constants shared by the gating control: register map, field positions, reset values, timing.
// Assumes a single 40 MHz system clock; all gate and delay values are in 0.1 ms units.
package jmgc_pkg;
	// ==========================================================
	// Timing
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned TICK_NS = 100000; // 0.1 ms resolution step.
	localparam int unsigned TICK_CYC = CLK_HZ / (1000000000 / TICK_NS);
	localparam int unsigned TCNT_W = 12;
	localparam logic [13:0] GATE_MIN_U = 14'd10; // 1.0 ms.
	localparam logic [13:0] GATE_MAX_U = 14'd10000; // 1000.0 ms.
	localparam logic [13:0] SUB_U = 14'd1000; // 100 ms sub-gate; split above this.
	localparam logic [13:0] FIX1_U = 14'd1000; // 0.1 s fixed gate.
	localparam logic [13:0] FIX5_U = 14'd5000; // 0.5 s fixed gate.
	localparam logic [13:0] DLY_MAX_U = 14'd10000; // 1000.0 ms arming delay.
	localparam logic [13:0] BLINK_U = 14'd2500; // Indicator half period, 250 ms.
	localparam logic [16:0] EVENT_N = 17'd100000; // Event gate sample count.
	localparam logic [9:0] PHASE_MAX = 10'd400; // 40.0 ns in 0.1 ns steps.
	// ==========================================================
	// Register offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_CMD = 8'h04;
	localparam logic [7:0] A_GATE = 8'h08;
	localparam logic [7:0] A_DELAY = 8'h0C;
	localparam logic [7:0] A_PHASE = 8'h10;
	localparam logic [7:0] A_STATUS = 8'h14;
	// ==========================================================
	// Field positions and encodings
	localparam int unsigned C_GATE = 0; // [1:0] gate select.
	localparam int unsigned C_SLOPE = 2; // [3:2] arming slope.
	localparam int unsigned C_INH = 4; // [5:4] inhibit polarity.
	localparam int unsigned C_D2C = 6;
	localparam int unsigned C_CFALL = 7;
	localparam int unsigned C_PHASE = 8;
	localparam int unsigned C_RUN = 9;
	localparam int unsigned C_SCALE = 10;
	localparam int unsigned K_PLL = 1; // Command bit: toggle regenerated clock.
	localparam logic [1:0] G_EVENT = 2'h0;
	localparam logic [1:0] G_FIX1 = 2'h1;
	localparam logic [1:0] G_FIX5 = 2'h2;
	localparam logic [1:0] G_MAN = 2'h3;
	localparam logic [1:0] SL_RISE = 2'h1;
	localparam logic [1:0] SL_FALL = 2'h2;
	localparam logic [1:0] INH_POS = 2'h1;
	localparam logic [1:0] INH_NEG = 2'h2;
	// ==========================================================
	// Reset values
	localparam logic [10:0] CTRL_RST = 11'h000;
	localparam logic [13:0] GATE_RST = 14'd1000;
	localparam logic [13:0] DELAY_RST = 14'd0;
	localparam logic [9:0] PHASE_RST = 10'd0;
	typedef enum logic [2:0] {S_IDLE, S_ARM, S_GATE, S_SUB, S_DONE} jmgc_state_e;
endpackage : jmgc_pkg

// >>> jmgc_arm_if.sv
// Interface carrying the 0.1 ms tick and the arming handshake between the gating modules.
// Assumes all members are driven in the clk_sys domain.
`timescale 1ns/1ps
interface jmgc_arm_if;
	logic tick;
	logic tick_clr;
	logic restart;
	logic [1:0] slope;
	logic [13:0] delay_u;
	logic arm_in;
	logic fire;
	modport tick_src (output tick, input tick_clr);
	modport ctl (input tick, output tick_clr, output restart, output slope, output delay_u,
		output arm_in, input fire);
	modport arm (input tick, input restart, input slope, input delay_u, input arm_in,
		output fire);
endinterface : jmgc_arm_if

// >>> jmgc_tick.sv
// Divider giving a one-cycle pulse every 0.1 ms.
// Assumes a 40 MHz clk_sys; a clear realigns the period to a gate start.
`timescale 1ns/1ps
module jmgc_tick #(
	parameter int unsigned CYC = jmgc_pkg::TICK_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	jmgc_arm_if.tick_src tif
);
	localparam logic [jmgc_pkg::TCNT_W-1:0] LAST = jmgc_pkg::TCNT_W'(CYC - 1);
	logic [jmgc_pkg::TCNT_W-1:0] cnt_q;
	logic tick_q;

	// ==========================================================
	// Cycle counter; the clear restarts a full period so a gate lasts whole steps.
	always_ff @(posedge clk_sys) begin
		if (rst || tif.tick_clr) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (cnt_q == LAST) begin
			cnt_q <= '0;
			tick_q <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	assign tif.tick = tick_q;
endmodule : jmgc_tick

// >>> jmgc_arm.sv
// Arming detector: auto arming, or selected external edge followed by a programmable delay.
// Assumes the external arming input is synchronous to clk_sys.
`timescale 1ns/1ps
module jmgc_arm (
	input wire logic clk_sys,
	input wire logic rst,
	jmgc_arm_if.arm aif
);
	logic prev_q;
	logic wait_q;
	logic fire_q;
	logic [13:0] dly_q;
	logic edge_hit;

	// Edge of the chosen slope; no slope chosen means internal auto arming.
	assign edge_hit = (aif.slope == jmgc_pkg::SL_RISE) ? (aif.arm_in && !prev_q) : // [R6]
		(aif.slope == jmgc_pkg::SL_FALL) ? (!aif.arm_in && prev_q) : 1'b1; // [R4]

	// ==========================================================
	// Previous input level for the edge compare.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= aif.arm_in;
		end
	end

	// ==========================================================
	// Arm once per restart: catch the edge, count delay ticks, then fire.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wait_q <= 1'b0;
			dly_q <= '0;
			fire_q <= 1'b0;
		end else begin
			fire_q <= 1'b0;
			if (aif.restart) begin
				wait_q <= 1'b1;
				dly_q <= '0;
			end else if (wait_q && dly_q == 14'd0 && edge_hit) begin
				if (aif.delay_u == 14'd0 || aif.slope == 2'h0 || aif.slope == 2'h3) begin
					wait_q <= 1'b0;
					fire_q <= 1'b1; // [R9]
				end else begin
					// One extra tick covers the partial step in flight, so the wait never falls short.
					dly_q <= aif.delay_u + 14'd1; // [R7]
				end
			end else if (wait_q && dly_q != 14'd0 && aif.tick) begin
				if (dly_q == 14'd1) begin
					wait_q <= 1'b0;
					fire_q <= 1'b1; // [R7]
				end
				dly_q <= dly_q - 14'd1;
			end
		end
	end

	assign aif.fire = fire_q;
endmodule : jmgc_arm

// >>> jmgc_props.sv
// Assertion checker for the gating control, bound to the top module.
// Assumes only the top ports, one clk_sys domain and a synchronous rst.
`timescale 1ns/1ps
module jmgc_props (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic measure_block_in,
	input wire logic pll_lock,
	input wire logic meas_enable,
	input wire logic subgate_done,
	input wire logic result_update,
	input wire logic clk_use_pll,
	input wire logic clk_edge_rise,
	input wire logic lock_lost_message,
	input wire logic meter_overrange,
	input wire logic dc_force_5v,
	input wire logic phase_led,
	input wire logic scale10_led,
	input wire logic scale20_led,
	input wire logic meter_phase_mode
);
	// ==========================================================
	// Helper logic
	logic [10:0] ctrl_q;
	logic inh_act;
	// Shadow of the control word, written as the real one is but without the phase bit clear.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_q <= jmgc_pkg::CTRL_RST;
		end else if (reg_wr && reg_addr == jmgc_pkg::A_CTRL) begin
			ctrl_q <= reg_wdata[10:0];
		end
	end
	// Inhibit input seen at its selected active level.
	assign inh_act = (ctrl_q[5:4] == jmgc_pkg::INH_POS && measure_block_in)
		|| (ctrl_q[5:4] == jmgc_pkg::INH_NEG && !measure_block_in);
	// ==========================================================
	// Properties
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_inhibit_blocks: assert property (inh_act |=> !meas_enable)
		else $error("measurement open while inhibited");
	a_regen_needs_d2c: assert property ($rose(clk_use_pll) |-> $past(ctrl_q[6], 2))
		else $error("regenerated clock chosen outside data to clock");
	a_regen_rise: assert property (clk_use_pll |-> clk_edge_rise)
		else $error("regenerated clock not on rising edge");
	a_lock_cause: assert property ($rose(lock_lost_message) |-> !$past(pll_lock))
		else $error("lock lost shown while locked");
	a_lock_outputs: assert property (lock_lost_message |-> meter_overrange && dc_force_5v)
		else $error("lock loss outputs incomplete");
	a_lock_stops: assert property (lock_lost_message |-> !meas_enable)
		else $error("measurement open while unlocked");
	a_update_single: assert property (result_update |=> !result_update)
		else $error("result update longer than one cycle");
	a_update_closed: assert property (result_update |-> !meas_enable)
		else $error("result update with gate open");
	a_sub_gap: assert property (subgate_done |-> ##[0:2] !meas_enable)
		else $error("no gap between sub gates");
	a_phase_scales: assert property (meter_phase_mode |-> scale10_led && scale20_led)
		else $error("phase mode without both scale lamps");
	a_phase_blink: assert property (phase_led |-> meter_phase_mode)
		else $error("phase lamp outside phase mode");
	c_update: cover property (result_update);
	c_subgate: cover property (subgate_done);
	c_lock_lost: cover property (lock_lost_message);
	c_phase: cover property (meter_phase_mode);
endmodule : jmgc_props

bind jmgc_top jmgc_props u_props (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr,
	.measure_block_in, .pll_lock, .meas_enable, .subgate_done, .result_update,
	.clk_use_pll, .clk_edge_rise, .lock_lost_message, .meter_overrange, .dc_force_5v,
	.phase_led, .scale10_led, .scale20_led, .meter_phase_mode);

// >>> jmgc_src_model.sv
// Model of the external TTL arming and inhibit sources.
// Assumes levels change just after a rising clk_sys edge.
`timescale 1ns/1ps
module jmgc_src_model (
	input wire logic clk_sys,
	output logic arm_out,
	output logic inh_out
);
	// ==========================================================
	// Source levels
	localparam int MIN_HOLD = 2; // Two 25 ns cycles cover the minimum pulse.
	// Both sources idle low.
	initial begin
		arm_out = 1'b0;
		inh_out = 1'b0;
	end
	// Sets one source level and holds it at least the minimum pulse width.
	task automatic set_src(input logic measure_block_select_key, input logic v, input int hold);
		@(posedge clk_sys);
		if (measure_block_select_key) begin
			inh_out <= v;
		end else begin
			arm_out <= v;
		end
		repeat ((hold < MIN_HOLD) ? MIN_HOLD : hold) @(posedge clk_sys);
		#1;
	endtask : set_src
endmodule : jmgc_src_model

// >>> jmgc_top_bench.sv
// Self-checking bench for the gating control.
// Assumes the source model on the arming and inhibit pins, a 40 MHz clock.
`timescale 1ns/1ps
module jmgc_top_bench;
	// ==========================================================
	// Signals
	localparam logic [31:0] RUN = 32'h200, D2C = 32'h40, CFALL = 32'h80, PH = 32'h100;
	localparam int TC = 8; // Short 0.1 ms step so that sub-gates fit in the run.
	logic clk_sys, rst, reg_wr, reg_rd, pll_lock, external_arming_input, measure_block_in;
	logic meas_enable, result_update, clk_use_pll, clk_edge_rise, lock_lost_message;
	logic meter_overrange, dc_force_5v, scale20_led, meter_phase_mode;
	logic sample_stb, subgate_done, pll_led, phase_led, scale10_led;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [9:0] meter_phase;
	int errors = 0, total_checks = 0, n, k;
	time t0;
	jmgc_top #(.TICK_CYC(TC)) u_dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .external_arming_input, .measure_block_in, .sample_stb, .pll_lock,
		.meas_enable, .subgate_done, .result_update, .clk_use_pll, .clk_edge_rise,
		.pll_led, .lock_lost_message, .meter_overrange, .dc_force_5v, .phase_led,
		.scale10_led, .scale20_led, .meter_phase_mode, .meter_phase);
	jmgc_src_model u_src (.clk_sys, .arm_out(external_arming_input),
		.inh_out(measure_block_in));
	// Clock of 25 ns period.
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// ==========================================================
	// Tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task tick(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask : tick
	// Write cycle, then time for registered outputs to follow.
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		tick(3);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : rd
	task do_reset;
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		tick(1);
	endtask : do_reset
	// Counts cycles until the gate opens, bounded.
	task wait_open(input int lim);
		n = 0;
		while (meas_enable !== 1'b1 && n < lim) begin
			tick(1);
			n++;
		end
	endtask : wait_open
	// Waits for the result pulse, bounded, counting sub-gate boundaries on the way.
	task wait_done(input int lim);
		n = 0;
		k = 0;
		while (result_update !== 1'b1 && n < lim) begin
			tick(1);
			n++;
			if (subgate_done === 1'b1) begin
				k++;
			end
		end
	endtask : wait_done
	task wrap_up;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up
	// Watchdog sized well above the longest gate.
	initial begin
		repeat (80000) @(posedge clk_sys);
		errors++;
		wrap_up();
	end
	// ==========================================================
	// Tests
	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		pll_lock = 1'b1;
		sample_stb = 1'b0;
		do_reset();
		rd(jmgc_pkg::A_CTRL, 32'h0);
		rd(jmgc_pkg::A_GATE, 32'h3E8);
		rd(8'h18, 32'h0);
		chk(clk_edge_rise, 1);
		wr(jmgc_pkg::A_GATE, 32'h5);
		rd(jmgc_pkg::A_GATE, 32'hA);
		wr(jmgc_pkg::A_GATE, 32'h4E20);
		rd(jmgc_pkg::A_GATE, 32'h2710);
		wr(jmgc_pkg::A_DELAY, 32'h4E20);
		rd(jmgc_pkg::A_DELAY, 32'h2710);
		wr(jmgc_pkg::A_PHASE, 32'h64);
		rd(jmgc_pkg::A_PHASE, 32'h0);
		wr(jmgc_pkg::A_CTRL, D2C | PH | CFALL);
		wr(jmgc_pkg::A_PHASE, 32'h1F4);
		chk(meter_phase, 32'h190);
		chk({meter_phase_mode, scale10_led, scale20_led, phase_led}, 32'hE);
		wr(jmgc_pkg::A_CMD, 32'h2);
		chk({clk_use_pll, clk_edge_rise, pll_led}, 7);
		@(posedge clk_sys);
		pll_lock <= 1'b0;
		tick(4);
		chk({lock_lost_message, meter_overrange, dc_force_5v, pll_led}, 32'hE);
		@(posedge clk_sys);
		pll_lock <= 1'b1;
		wr(jmgc_pkg::A_CMD, 32'h2);
		chk({clk_use_pll, clk_edge_rise, lock_lost_message}, 0);
		wr(jmgc_pkg::A_CTRL, 32'h0);
		wr(jmgc_pkg::A_CMD, 32'h2);
		chk(clk_use_pll, 0);
		do_reset();
		wr(jmgc_pkg::A_CTRL, RUN | 32'h9);
		u_src.set_src(1'b0, 1'b1, 100);
		chk(meas_enable, 0);
		u_src.set_src(1'b0, 1'b0, 2);
		wait_open(20);
		chk(n <= 6, 1);
		t0 = $time;
		wait_done(9000);
		n = int'(($time - t0) / 25);
		chk(n >= 1000 * TC - 10 && n <= 1000 * TC + 10, 1);
		chk(k, 0);
		do_reset();
		wr(jmgc_pkg::A_DELAY, 32'h10);
		wr(jmgc_pkg::A_CTRL, RUN | 32'h4);
		tick(100);
		chk(meas_enable, 0);
		u_src.set_src(1'b0, 1'b1, 2);
		wait_open(200);
		chk(n > 16 * TC && n <= 17 * TC + 2, 1);
		@(posedge clk_sys);
		sample_stb <= 1'b1;
		repeat (5) @(posedge clk_sys);
		sample_stb <= 1'b0;
		rd(jmgc_pkg::A_STATUS, 32'h00400005);
		do_reset();
		wr(jmgc_pkg::A_GATE, 32'h9C4);
		chk(meas_enable, 0);
		wr(jmgc_pkg::A_CTRL, RUN | 32'h13);
		wait_open(20);
		chk(n < 20, 1);
		t0 = $time;
		tick(100);
		u_src.set_src(1'b1, 1'b1, 50);
		chk(meas_enable, 0);
		u_src.set_src(1'b1, 1'b0, 4);
		chk(meas_enable, 1);
		wr(jmgc_pkg::A_CTRL, RUN | 32'h3);
		u_src.set_src(1'b1, 1'b1, 5);
		chk(meas_enable, 1);
		u_src.set_src(1'b1, 1'b0, 2);
		wr(jmgc_pkg::A_CTRL, RUN | 32'h23);
		chk(meas_enable, 0);
		wr(jmgc_pkg::A_CTRL, RUN | 32'h3);
		wait_done(25000);
		n = int'(($time - t0) / 25);
		chk(n >= 2500 * TC - 10 && n <= 2500 * TC + 10, 1);
		chk(k, 2);
		wrap_up();
	end
endmodule : jmgc_top_bench
